// ---- common/eeprom_write_guard_defines.vh ----
`ifndef EEPROM_WRITE_GUARD_DEFINES_VH
`define EEPROM_WRITE_GUARD_DEFINES_VH

// register byte offsets
`define OFS_CTRL        8'h00
`define OFS_ADDR        8'h04
`define OFS_DATA        8'h08
`define OFS_UNLOCK      8'h0C
`define OFS_IRQ_STATUS  8'h10
`define OFS_IRQ_MASK    8'h14
`define OFS_STATUS      8'h18

// control register fields
`define CTRL_RD         0
`define CTRL_WR         1
`define CTRL_WRITE_ENABLE_BIT       2
`define CTRL_WRITE_ERROR_FLAG      3

// interrupt status / mask fields
`define IRQ_DONE        0
`define IRQ_ERR         1
`define IRQ_W           2

// status register fields
`define ST_PWRT         0
`define ST_BUSY         1
`define ST_PROT         2

// unlock sequence keys
`define UNLOCK_KEY1     8'h55
`define UNLOCK_KEY2     8'hAA

// timing
`define CLK_PERIOD_NS   8
`define PWRT_TIME_MS    64
`define NS_PER_MS       1000000
`define PWRT_CYCLES     ((`PWRT_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define WRITE_CYCLES    64

// reset values
`define RST_BYTE        8'h00
`define RST_WORD        32'h0000_0000

`endif

// ---- rtl/eeprom_write_guard.v ----
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_write_guard_defines.vh"

module eeprom_write_guard #(
   parameter ADDR_W       = 8,
   parameter PWRT_CYCLES  = `PWRT_CYCLES,
   parameter WRITE_CYCLES = `WRITE_CYCLES
) (
   // apb clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [7:0]  paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // cpu-side reset sources that may cut a write short
   input  wire        external_master_reset,
   input  wire        watchdog_timer,
   // configuration fuse, active low
   input  wire        data_protect_fuse,
   // external programmer port
   input  wire        prog_req,
   input  wire        prog_we,
   input  wire [7:0]  prog_addr,
   input  wire [7:0]  prog_wdata,
   output reg  [7:0]  prog_rdata,
   output reg         prog_ack,
   output reg         prog_denied,
   // interrupt
   output reg         irq
);

   localparam ST_IDLE  = 1'b0;           // no write in flight
   localparam ST_WRITE = 1'b1;           // charge pump timing a write
   localparam DEPTH    = 1 << ADDR_W;

   reg [7:0]        mem [0:DEPTH-1];     // data eeprom array
   reg [ADDR_W-1:0] addr_r;              // address register
   reg [7:0]        data_r;              // eeprom_data_reg
   reg              rd_r;                // read trigger
   reg              wr_r;                // write trigger
   reg              write_enable_bit_r;  // write enable
   reg              state_r;             // write state
   reg [31:0]       wcnt_r;              // write timer
   reg [31:0]       pwrt_cnt_r;          // power-up timer
   reg              pwrt_busy_r;         // power-up timer running
   reg [1:0]        unlock_r;            // unlock sequence progress
   reg [`IRQ_W-1:0] irq_status_r;        // sticky event flags
   reg [`IRQ_W-1:0] irq_mask_r;          // interrupt mask
   reg [ADDR_W-1:0] wr_addr_r;           // address latched at write start
   reg [7:0]        wr_data_r;           // data latched at write start

   wire protect_on = ~data_protect_fuse;
   wire apb_acc    = psel & penable & pready;                // completing access
   wire apb_wr     = apb_acc & pwrite;
   wire cut_reset  = external_master_reset | watchdog_timer;
   wire write_done = (state_r == ST_WRITE) && (wcnt_r == 32'd0) && !cut_reset;
   wire write_cut  = (state_r == ST_WRITE) && cut_reset;

   // register decode, also tells the bus which offsets exist
   function mapped;
      input [7:0] a;
      begin
         if (a == `OFS_CTRL) mapped = 1'b1;
         else if (a == `OFS_ADDR) mapped = 1'b1;
         else if (a == `OFS_DATA) mapped = 1'b1;
         else if (a == `OFS_UNLOCK) mapped = 1'b1;
         else if (a == `OFS_IRQ_STATUS) mapped = 1'b1;
         else if (a == `OFS_IRQ_MASK) mapped = 1'b1;
         else if (a == `OFS_STATUS) mapped = 1'b1;
         else mapped = 1'b0;
      end
   endfunction

   // write start: enable, full unlock, timer expired, nothing in flight
   wire start_ok = write_enable_bit_r && (unlock_r == 2'd2) &&
                   !pwrt_busy_r && (state_r == ST_IDLE);
   wire ctrl_wr  = apb_wr && (paddr == `OFS_CTRL);

   // read-back mux, values registered into prdata
   reg [31:0] rdata_nxt;
   always @* begin
      rdata_nxt = `RST_WORD;
      if (paddr == `OFS_CTRL) begin
         rdata_nxt[`CTRL_RD]    = rd_r;
         rdata_nxt[`CTRL_WR]    = wr_r;
         rdata_nxt[`CTRL_WRITE_ENABLE_BIT]  = write_enable_bit_r;
         rdata_nxt[`CTRL_WRITE_ERROR_FLAG] = irq_status_r[`IRQ_ERR];
      end else if (paddr == `OFS_ADDR) begin
         rdata_nxt[ADDR_W-1:0] = addr_r;
      end else if (paddr == `OFS_DATA) begin
         rdata_nxt[7:0] = data_r;
      end else if (paddr == `OFS_IRQ_STATUS) begin
         rdata_nxt[`IRQ_W-1:0] = irq_status_r;
      end else if (paddr == `OFS_IRQ_MASK) begin
         rdata_nxt[`IRQ_W-1:0] = irq_mask_r;
      end else if (paddr == `OFS_STATUS) begin
         rdata_nxt[`ST_PWRT] = pwrt_busy_r;
         rdata_nxt[`ST_BUSY] = (state_r == ST_WRITE);
         rdata_nxt[`ST_PROT] = protect_on;
      end
      // unlock register reads as zero, its progress in unlock_r is not readable
   end

   // apb handshake: one wait state so read data comes from a flop
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= `RST_WORD;
      end else if (psel && penable && !pready) begin
         pready  <= 1'b1;
         pslverr <= !mapped(paddr);
         prdata  <= pwrite ? `RST_WORD : rdata_nxt;
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // power-up timer, runs once after power-on reset release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwrt_cnt_r  <= 32'd0;
         pwrt_busy_r <= 1'b1;
      end else if (pwrt_busy_r) begin
         if (pwrt_cnt_r == PWRT_CYCLES - 1)
            pwrt_busy_r <= 1'b0;
         pwrt_cnt_r <= pwrt_cnt_r + 32'd1;
      end
   end

   // unlock sequence: key1 then key2; any other write restarts it
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_r <= 2'd0;
      end else if (apb_wr) begin
         if (paddr == `OFS_UNLOCK && pwdata[7:0] == `UNLOCK_KEY1)
            unlock_r <= 2'd1;
         else if (paddr == `OFS_UNLOCK && pwdata[7:0] == `UNLOCK_KEY2 && unlock_r == 2'd1)
            unlock_r <= 2'd2;
         else
            unlock_r <= 2'd0;   // ctrl write consumes it, so one unlock per write
      end
   end

   // control, address, data registers and the write engine
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_r             <= {ADDR_W{1'b0}};
         data_r             <= `RST_BYTE;
         rd_r               <= 1'b0;
         wr_r               <= 1'b0;
         write_enable_bit_r <= 1'b0;
         state_r            <= ST_IDLE;
         wcnt_r             <= 32'd0;
         wr_addr_r          <= {ADDR_W{1'b0}};
         wr_data_r          <= `RST_BYTE;
      end else begin
         // a pending read completes one cycle after its trigger
         if (rd_r) begin
            data_r <= mem[addr_r];
            rd_r   <= 1'b0;
         end
         if (apb_wr && paddr == `OFS_ADDR)
            addr_r <= pwdata[ADDR_W-1:0];
         if (apb_wr && paddr == `OFS_DATA)
            data_r <= pwdata[7:0];
         if (ctrl_wr) begin
            write_enable_bit_r <= pwdata[`CTRL_WRITE_ENABLE_BIT];
            // triggers only set; a zero written leaves them alone
            if (pwdata[`CTRL_RD] && state_r == ST_IDLE)
               rd_r <= 1'b1;
            if (pwdata[`CTRL_WR] && start_ok) begin
               wr_r      <= 1'b1;
               state_r   <= ST_WRITE;
               wcnt_r    <= WRITE_CYCLES - 1;
               wr_addr_r <= addr_r;
               wr_data_r <= data_r;
            end
         end
         case (state_r)
            ST_IDLE: begin
               // the start above loads the counter; clearing it here would
               // override that load and end every write after one cycle
            end
            ST_WRITE: begin
               if (cut_reset) begin
                  // cut short: location left unwritten, enable dropped
                  state_r            <= ST_IDLE;
                  wr_r               <= 1'b0;
                  write_enable_bit_r <= 1'b0;
               end else if (wcnt_r == 32'd0) begin
                  state_r <= ST_IDLE;
                  wr_r    <= 1'b0;
               end else begin
                  wcnt_r <= wcnt_r - 32'd1;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // array writes: cpu write completion, or an unprotected programmer
   always @(posedge pclk) begin
      if (write_done)
         mem[wr_addr_r] <= wr_data_r;
      else if (prog_req && prog_we && !protect_on)
         mem[prog_addr] <= prog_wdata;
   end

   // programmer port; a cpu write completing in the same cycle takes the array and the programmer write is lost
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prog_rdata  <= `RST_BYTE;
         prog_ack    <= 1'b0;
         prog_denied <= 1'b0;
      end else begin
         prog_ack    <= prog_req && !protect_on;
         prog_denied <= prog_req && protect_on;
         if (prog_req && !protect_on && !prog_we)
            prog_rdata <= mem[prog_addr];
         else
            prog_rdata <= `RST_BYTE;   // protected data never leaks out
      end
   end

   // sticky interrupt flags, write one to clear, set wins
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_r <= {`IRQ_W{1'b0}};
         irq_mask_r   <= {`IRQ_W{1'b0}};
         irq          <= 1'b0;
      end else begin
         if (apb_wr && paddr == `OFS_IRQ_MASK)
            irq_mask_r <= pwdata[`IRQ_W-1:0];
         irq_status_r[`IRQ_DONE] <= write_done |
            (irq_status_r[`IRQ_DONE] &
             ~(apb_wr && paddr == `OFS_IRQ_STATUS && pwdata[`IRQ_DONE]));
         irq_status_r[`IRQ_ERR] <= write_cut |
            (irq_status_r[`IRQ_ERR] &
             ~(apb_wr && paddr == `OFS_IRQ_STATUS && pwdata[`IRQ_ERR]));
         irq <= |(irq_status_r & irq_mask_r);
      end
   end

endmodule

`default_nettype wire

// ---- test/eeprom_write_guard_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module eeprom_write_guard_monitor #(parameter PWRT_CYCLES = 20) (
   // apb side
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr,
   // programmer port, fuse and interrupt
   input wire logic       prog_req,
   input wire logic       data_protect_fuse,
   input wire logic       prog_ack,
   input wire logic       prog_denied,
   input wire logic [7:0] prog_rdata,
   input wire logic       irq
);
   int unsigned up_cnt_r; // cycles since reset release
   // saturates so it never wraps back into the power-up window
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) up_cnt_r <= 0;
      else if (up_cnt_r < PWRT_CYCLES) up_cnt_r <= up_cnt_r + 1;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_one_wait; psel && penable && !pready |=> pready; endproperty
   a_one_wait: assert property (p_one_wait) else $error("pready not after one wait");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("pready too long");
   property p_err_with_ready; pslverr |-> pready && psel && penable; endproperty
   a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
   property p_open_ack; prog_req && data_protect_fuse |=> prog_ack && !prog_denied; endproperty
   a_open_ack: assert property (p_open_ack) else $error("programmer not served");
   property p_deny; prog_req && !data_protect_fuse |=> prog_denied && !prog_ack; endproperty
   a_deny: assert property (p_deny) else $error("programmer not denied");
   property p_idle; !prog_req |=> !prog_ack && !prog_denied; endproperty
   a_idle: assert property (p_idle) else $error("programmer answer without request");
   property p_deny_zero; prog_denied |-> prog_rdata == 8'h00; endproperty
   a_deny_zero: assert property (p_deny_zero) else $error("data leaked on deny");
   property p_pwrt_quiet; up_cnt_r < PWRT_CYCLES |-> !irq; endproperty
   a_pwrt_quiet: assert property (p_pwrt_quiet) else $error("write event in power-up");
endmodule
bind eeprom_write_guard eeprom_write_guard_monitor #(.PWRT_CYCLES(PWRT_CYCLES)) mon_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .prog_req(prog_req), .data_protect_fuse(data_protect_fuse),
   .prog_ack(prog_ack), .prog_denied(prog_denied), .prog_rdata(prog_rdata), .irq(irq));
`default_nettype wire

// ---- test/test_eeprom_write_guard.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_write_guard_defines.vh"
module test_eeprom_write_guard;
   // bench-driven inputs
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00, prog_addr = 8'h5A, prog_wdata = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        external_master_reset = 0, watchdog_timer = 0, data_protect_fuse = 1;
   logic        prog_req = 0, prog_we = 0;
   // design outputs
   logic [31:0] prdata;
   logic        pready, pslverr, irq, prog_ack, prog_denied;
   logic [7:0]  prog_rdata;
   int          n_fail = 0, tests_run = 0, cyc = 0;
   logic [31:0] rd_v; // last read data
   logic        rd_e; // last pslverr
   // offset, write value, expected read back, expected error
   logic [72:0] rows [5] = '{{`OFS_ADDR, 32'h5A, 32'h5A, 1'b0},
      {`OFS_DATA, 32'h3C, 32'h3C, 1'b0}, {`OFS_IRQ_MASK, 32'h3, 32'h3, 1'b0},
      {`OFS_UNLOCK, 32'h55, 32'h0, 1'b0}, {8'h40, 32'hFF, 32'h0, 1'b1}};
   // short timer counts keep the run small
   eeprom_write_guard #(.PWRT_CYCLES(60), .WRITE_CYCLES(16)) dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_master_reset(external_master_reset), .watchdog_timer(watchdog_timer),
      .data_protect_fuse(data_protect_fuse), .prog_req(prog_req), .prog_we(prog_we),
      .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
      .prog_ack(prog_ack), .prog_denied(prog_denied), .irq(irq));
   initial forever #4 pclk = ~pclk;
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 3000) begin
         n_fail++;
         report_and_stop;
      end
   end
   task report_and_stop;
      if (n_fail == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one apb transfer; the request holds until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd_v = prdata;
      rd_e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // two-key unlock then start with write enable kept set
   task unlock_go;
      apb(1, `OFS_UNLOCK, `UNLOCK_KEY1);
      apb(1, `OFS_UNLOCK, `UNLOCK_KEY2);
      apb(1, `OFS_CTRL, 32'h6);
   endtask
   // polls a register until the given bit drops
   task wait_clear(input logic [7:0] a, input int b);
      do apb(0, a, 0); while (rd_v[b] !== 1'b0);
   endtask
   // one programmer request cycle; answer checked one cycle later
   task prg(input logic we, input logic [7:0] d, input logic [9:0] exp);
      @(posedge pclk);
      prog_req <= 1'b1; prog_we <= we; prog_wdata <= d;
      @(posedge pclk);
      prog_req <= 1'b0;
      #1 chk("prog answer", exp, {prog_ack, prog_denied, prog_rdata});
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, `OFS_CTRL, 0); chk("ctrl reset", 0, rd_v);
      apb(0, `OFS_STATUS, 0); chk("timer running", 1, rd_v[0]);
      apb(1, `OFS_CTRL, 32'h4); unlock_go;
      apb(0, `OFS_CTRL, 0); chk("early start", 0, rd_v[1]);
      wait_clear(`OFS_STATUS, 0);
      foreach (rows[i]) begin
         apb(1, rows[i][72:65], rows[i][64:33]);
         apb(0, rows[i][72:65], 0);
         chk("reg read", rows[i][32:1], rd_v);
         chk("reg error", rows[i][0], rd_e);
      end
      // a foreign write between the keys spoils the unlock
      apb(1, `OFS_UNLOCK, `UNLOCK_KEY1); apb(1, `OFS_DATA, 32'h3C);
      apb(1, `OFS_UNLOCK, `UNLOCK_KEY2); apb(1, `OFS_CTRL, 32'h6);
      apb(0, `OFS_STATUS, 0); chk("spoiled start", 0, rd_v[1]);
      unlock_go; apb(1, `OFS_CTRL, 32'h4);
      apb(0, `OFS_CTRL, 0); chk("trigger held", 32'h6, rd_v);
      wait_clear(`OFS_CTRL, 1);
      apb(0, `OFS_IRQ_STATUS, 0); chk("done flag", 1, rd_v);
      chk("irq set", 1, irq);
      apb(1, `OFS_IRQ_STATUS, 1); @(posedge pclk);
      #1 chk("irq clear", 0, irq);
      apb(1, `OFS_DATA, 0); apb(1, `OFS_CTRL, 32'h5);
      apb(0, `OFS_DATA, 0); chk("read back", 32'h3C, rd_v);
      apb(0, `OFS_CTRL, 0); chk("read trigger", 32'h4, rd_v);
      prg(0, 8'h00, {2'b10, 8'h3C});
      @(posedge pclk) data_protect_fuse <= 1'b0;
      prg(0, 8'h00, 10'h100);
      prg(1, 8'hFF, 10'h100);
      apb(0, `OFS_STATUS, 0); chk("protected", 1, rd_v[2]);
      apb(1, `OFS_CTRL, 32'h5);
      apb(0, `OFS_DATA, 0); chk("cpu read", 32'h3C, rd_v);
      @(posedge pclk) data_protect_fuse <= 1'b1;
      prg(0, 8'h00, {2'b10, 8'h3C});
      // cut a write short by each reset source in turn
      for (int i = 0; i < 2; i++) begin
         apb(1, `OFS_CTRL, 32'h4); apb(1, `OFS_DATA, 32'h77); unlock_go;
         @(posedge pclk);
         external_master_reset <= (i == 0); watchdog_timer <= (i == 1);
         @(posedge pclk);
         external_master_reset <= 1'b0; watchdog_timer <= 1'b0;
         apb(0, `OFS_IRQ_STATUS, 0); chk("error flag", 2, rd_v);
         apb(0, `OFS_CTRL, 0); chk("ctrl after cut", 32'h8, rd_v);
         apb(1, `OFS_IRQ_STATUS, 2); apb(1, `OFS_CTRL, 32'h5);
         apb(0, `OFS_DATA, 0); chk("byte kept", 32'h3C, rd_v);
      end
      report_and_stop;
   end
endmodule
`default_nettype wire
